// >>> inc/iem_pkg.sv
// constants and types for the input supervision and energy meter bank
package iem_pkg;
    // ********************
    // command codes
    // ********************
    localparam logic [7:0] CMD_VIN_ON  = 8'h35;
    localparam logic [7:0] CMD_VIN_OFF = 8'h36;
    localparam logic [7:0] CMD_OV_FLT  = 8'h55;
    localparam logic [7:0] CMD_OV_WRN  = 8'h57;
    localparam logic [7:0] CMD_UV_WRN  = 8'h58;
    localparam logic [7:0] CMD_UV_FLT  = 8'h59;
    localparam logic [7:0] CMD_EIN     = 8'hC0;
    localparam logic [7:0] CMD_EIN_CFG = 8'hC1;
    localparam logic [7:0] CMD_GAIN_TC = 8'hC3;
    localparam logic [7:0] CMD_CLR     = 8'hCC;
    localparam logic [7:0] CMD_GAIN    = 8'hE8;
    // ********************
    // reset values
    // ********************
    localparam logic [15:0] RST_VIN_ON  = 16'hD280;
    localparam logic [15:0] RST_VIN_OFF = 16'hD240;
    localparam logic [15:0] RST_OV_FLT  = 16'hD3C0;
    localparam logic [15:0] RST_OV_WRN  = 16'hD380;
    localparam logic [15:0] RST_UV_WRN  = 16'h8000;
    localparam logic [15:0] RST_UV_FLT  = 16'h8000;
    localparam logic [15:0] RST_GAIN_TC = 16'h0000;
    localparam logic [15:0] RST_GAIN    = 16'hBA00;
    localparam logic [7:0]  RST_CFG     = 8'h00;
    // ********************
    // limit table layout
    // ********************
    localparam int         NUM_LIM = 6;
    localparam logic [2:0] LIM_ON  = 3'h0;
    localparam logic [2:0] LIM_OFF = 3'h1;
    localparam logic [2:0] LIM_NONE = 3'h7;
    localparam int         LIM_FLAG0 = 2;
    localparam int         NUM_FLAG = 4;
    localparam int         NUM_OV_FLAG = 2;
    // ********************
    // config byte fields
    // ********************
    localparam int         CFG_HD_BIT = 2;
    localparam logic [7:0] CFG_MASK   = 8'h07;
    // ********************
    // meter layout and timing
    // ********************
    localparam int          CNT_W      = 48;
    localparam logic [15:0] BLK_BYTES  = 16'h000C;
    localparam int          RESID_W    = 34;
    localparam int          NJ_PER_MJ  = 1_000_000;
    localparam int          MV_PER_V   = 1000;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          MS_NS      = 1_000_000;
    localparam int          CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int          TOFF_MS    = 10;
    localparam logic [1:0]  WP_NONE    = 2'h0;
    localparam int          NUM_OTHER  = 6;
    localparam logic [3:0]  ADC_CH_VIN = 4'hE;
    localparam logic [3:0]  ADC_CH_IIN = 4'hF;
    localparam int          NUM_OUT    = 2;
    typedef enum logic [1:0] {
        SEQ_OTHER = 2'b00,
        SEQ_VIN   = 2'b01,
        SEQ_IIN   = 2'b10
    } iem_seq_t;
endpackage

// >>> hw/iem_ms_tick.sv
// millisecond enable divider, restartable
`timescale 1ns/100ps
`default_nettype none
module iem_ms_tick #(
    parameter int unsigned CYC = 40000
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_restart,
    output logic      o_tick
);
    localparam int W = $clog2(CYC);
    localparam logic [W-1:0] LAST = W'(CYC - 1);
    logic [W-1:0] cnt_r;

    // restart keeps the first tick after a clear one full ms away
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt_r == LAST);
            cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> hw/iem_top.sv
// input supervision limits and input energy meter command bank
`timescale 1ns/100ps
`default_nettype none
// Function
// - turn-on threshold word at 0x35, reset 0xD280, enables conversion above it
// - turn-off word at 0x36, reset 0xD240; below it outputs drop now or delayed
// - overvoltage fault word at 0x55, reset 0xD3C0, compared with input sense
// - overvoltage warning word at 0x57, reset 0xD380, compared with input sense
// - undervoltage warning word at 0x58, reset 0x8000
// - undervoltage fault word at 0x59, reset 0x8000
// - energy is the accumulated product of voltage and current readings
// - energy is unsigned 48-bit mJ in block bytes 0..5, low byte first
// - time is 48-bit ms since last clear in block bytes 6..11, low first
// - writing config byte or clear command zeroes energy and time
// - energy and time counters wrap to zero instead of saturating
// - high-definition mode measures voltage and current after every other measurement
// - energy and time are reported as a pair from one instant
// - read-only 12-byte energy block at 0xC0, no default
// - block read freezes visible copy; internal accumulation keeps running
// - channel off may decrement energy, never below zero
// - config byte at 0xC1, reset 0, sets energy and current measurement
// - gain tempco word at 0xC3, reset 0x0, ppm per degree
// - sense resistance word at 0xE8, reset 0xBA00, milliohms
// - host clears meter with data-less send byte 0xCC; device accepts it
// - config bit 2 selects high-definition sequence; bits 7..3 read zero
// - config bits 1..0 select sense amplifier range high, medium, low, reserved
// - clear accepted under write protect; may apply up to one update late
module iem_top
    import iem_pkg::*;
#(
    parameter int unsigned P_CYC_PER_MS = CYC_PER_MS,
    parameter int unsigned P_TOFF_MS    = TOFF_MS,
    parameter int unsigned P_NUM_OTHER  = NUM_OTHER
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    input  wire logic [1:0]  i_wp_level,
    input  wire logic        i_blk_active,
    input  wire logic [3:0]  i_blk_idx,
    input  wire logic        i_adc_done,
    input  wire logic [15:0] i_adc_data,
    input  wire logic        i_chan_off,
    input  wire logic        i_off_sequenced,
    output logic             o_cmd_ack,
    output logic             o_cmd_nack,
    output logic [15:0]      o_rd_data,
    output logic [7:0]       o_blk_byte,
    output logic [3:0]       o_adc_sel,
    output logic             o_hd_select,
    output logic [1:0]       o_iin_range,
    output logic [15:0]      o_tempco,
    output logic [15:0]      o_sense_gain,
    output logic             o_conv_en,
    output logic [NUM_OUT-1:0] o_out_en,
    output logic [NUM_FLAG-1:0] o_limit_flags
);
    localparam logic [15:0] RST_LIM [NUM_LIM] = '{RST_VIN_ON, RST_VIN_OFF, RST_OV_FLT,
                                                  RST_OV_WRN, RST_UV_WRN, RST_UV_FLT};
    localparam logic [RESID_W-1:0] NJ_STEP = RESID_W'(NJ_PER_MJ);
    localparam int OW = $clog2(P_NUM_OTHER + 1);
    localparam logic [OW-1:0] OTHER_LAST = OW'(P_NUM_OTHER - 1);
    localparam int DW = $clog2(P_TOFF_MS + 1);
    localparam logic [DW-1:0] TOFF_CNT = DW'(P_TOFF_MS);

    logic [15:0]         lim_r [NUM_LIM];
    logic [7:0]          cfg_r;
    logic [CNT_W-1:0]    energy_r;
    logic [CNT_W-1:0]    time_r;
    logic [RESID_W-1:0]  resid_r;
    logic [CNT_W-1:0]    snap_e_r;
    logic [CNT_W-1:0]    snap_t_r;
    logic [15:0]         vin_r;
    logic [31:0]         power_r;
    logic [OW-1:0]       other_r;
    iem_seq_t            seq_r;
    logic                clr_pend_r;
    logic                clr_apply;
    logic                tick;
    logic                wr_ok;
    logic                clr_req;
    logic [2:0]          lim_idx;
    logic                drain;
    logic signed [31:0]  vin_mv;
    logic [2*CNT_W-1:0]  blk_vec;

    // ********************
    // helpers
    // ********************
    function automatic logic [2:0] lim_index(input logic [7:0] code);
        case (code)
            CMD_VIN_ON:  lim_index = 3'h0;
            CMD_VIN_OFF: lim_index = 3'h1;
            CMD_OV_FLT:  lim_index = 3'h2;
            CMD_OV_WRN:  lim_index = 3'h3;
            CMD_UV_WRN:  lim_index = 3'h4;
            CMD_UV_FLT:  lim_index = 3'h5;
            default:     lim_index = LIM_NONE;
        endcase
    endfunction

    // linear 11-bit word to signed millivolts
    function automatic logic signed [31:0] l11_mv(input logic [15:0] w);
        logic signed [31:0] m;
        int ev;
        m  = 32'(signed'(w[10:0])) * MV_PER_V;
        ev = int'(signed'(w[15:11]));
        l11_mv = (ev >= 0) ? (m <<< ev) : (m >>> (-ev));
    endfunction

    iem_ms_tick #(
        .CYC       (P_CYC_PER_MS)
    ) u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_restart (clr_apply),
        .o_tick    (tick)
    );

    // ********************
    // command decode
    // ********************
    assign lim_idx = lim_index(i_cmd_code);
    assign clr_req = i_cmd_valid && i_cmd_write && i_cmd_code == CMD_CLR;
    assign wr_ok   = i_cmd_valid && i_cmd_write && (i_wp_level == WP_NONE);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < NUM_LIM; k++) begin
                lim_r[k] <= RST_LIM[k];
            end
        end else if (wr_ok && lim_idx != LIM_NONE) begin
            lim_r[lim_idx] <= i_cmd_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= RST_CFG;
        end else if (wr_ok && i_cmd_code == CMD_EIN_CFG) begin
            cfg_r <= i_cmd_wdata[7:0] & CFG_MASK;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tempco     <= RST_GAIN_TC;
            o_sense_gain <= RST_GAIN;
        end else if (wr_ok) begin
            if (i_cmd_code == CMD_GAIN_TC) begin
                o_tempco <= i_cmd_wdata;
            end
            if (i_cmd_code == CMD_GAIN) begin
                o_sense_gain <= i_cmd_wdata;
            end
        end
    end

    // energy block read-only; reads answer its byte count
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cmd_ack  <= 1'b0;
            o_cmd_nack <= 1'b0;
            o_rd_data  <= '0;
        end else begin
            o_cmd_ack  <= 1'b0;
            o_cmd_nack <= 1'b0;
            if (i_cmd_valid && i_cmd_write) begin
                o_cmd_ack  <= clr_req || (wr_ok && (lim_idx != LIM_NONE
                              || i_cmd_code == CMD_EIN_CFG || i_cmd_code == CMD_GAIN_TC
                              || i_cmd_code == CMD_GAIN));
                o_cmd_nack <= !(clr_req || (wr_ok && (lim_idx != LIM_NONE
                              || i_cmd_code == CMD_EIN_CFG || i_cmd_code == CMD_GAIN_TC
                              || i_cmd_code == CMD_GAIN)));
            end else if (i_cmd_valid) begin
                o_cmd_ack <= 1'b1;
                if (lim_idx != LIM_NONE) begin
                    o_rd_data <= lim_r[lim_idx];
                end else begin
                    case (i_cmd_code)
                        CMD_EIN:     o_rd_data <= BLK_BYTES;
                        CMD_EIN_CFG: o_rd_data <= {8'h00, cfg_r};
                        CMD_GAIN_TC: o_rd_data <= o_tempco;
                        CMD_GAIN:    o_rd_data <= o_sense_gain;
                        default: begin
                            o_rd_data  <= '0;
                            o_cmd_ack  <= 1'b0;
                            o_cmd_nack <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ********************
    // meter clear
    // ********************
    // config write or clear request arms the clear
    // applied only off a tick so an update in flight is never split
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clr_pend_r <= 1'b0;
        end else if (clr_req || (wr_ok && i_cmd_code == CMD_EIN_CFG)) begin
            clr_pend_r <= 1'b1;
        end else if (clr_apply) begin
            clr_pend_r <= 1'b0;
        end
    end
    // deferred while a tick is being processed
    assign clr_apply = clr_pend_r && !tick;

    // ********************
    // adc scheduling and readings
    // ********************
    // high-definition pairs after every other measurement
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_r     <= SEQ_OTHER;
            other_r   <= '0;
            o_adc_sel <= '0;
        end else if (i_adc_done) begin
            case (seq_r)
                SEQ_OTHER: begin
                    other_r <= (other_r == OTHER_LAST) ? '0 : other_r + 1'b1;
                    if (cfg_r[CFG_HD_BIT] || other_r == OTHER_LAST) begin
                        seq_r     <= SEQ_VIN;
                        o_adc_sel <= ADC_CH_VIN;
                    end else begin
                        o_adc_sel <= 4'(other_r + 1'b1);
                    end
                end
                SEQ_VIN: begin
                    seq_r     <= SEQ_IIN;
                    o_adc_sel <= ADC_CH_IIN;
                end
                SEQ_IIN: begin
                    seq_r     <= SEQ_OTHER;
                    o_adc_sel <= 4'(other_r);
                end
                default: begin
                    seq_r     <= SEQ_OTHER;
                    o_adc_sel <= '0;
                end
            endcase
        end
    end

    // power from the voltage and current pair
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vin_r   <= '0;
            power_r <= '0;
        end else if (i_adc_done && seq_r == SEQ_VIN) begin
            vin_r <= i_adc_data;
        end else if (i_adc_done && seq_r == SEQ_IIN) begin
            power_r <= vin_r * i_adc_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hd_select <= 1'b0;
            o_iin_range <= '0;
        end else begin
            o_hd_select <= cfg_r[CFG_HD_BIT];
            o_iin_range <= cfg_r[1:0];
        end
    end

    // ********************
    // energy and time
    // ********************
    assign drain = !i_chan_off && resid_r >= NJ_STEP;

    // held power integrated per ms, one uW-ms is one nJ
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            energy_r <= '0;
            resid_r  <= '0;
        end else if (clr_apply) begin
            energy_r <= '0;
            resid_r  <= '0;
        end else if (i_chan_off) begin
            if (tick) begin
                if (resid_r >= RESID_W'(power_r)) begin
                    resid_r <= resid_r - RESID_W'(power_r);
                end else begin
                    resid_r <= '0;
                    if (energy_r != '0) begin
                        energy_r <= energy_r - 1'b1;
                    end
                end
            end
        end else begin
            resid_r  <= resid_r + (tick ? RESID_W'(power_r) : '0) - (drain ? NJ_STEP : '0);
            energy_r <= energy_r + CNT_W'(drain);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            time_r <= '0;
        end else if (clr_apply) begin
            time_r <= '0;
        end else if (tick) begin
            time_r <= time_r + 1'b1;
        end
    end

    // both copies taken in one cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snap_e_r <= '0;
            snap_t_r <= '0;
        end else if (!i_blk_active) begin
            snap_e_r <= energy_r;
            snap_t_r <= time_r;
        end
    end

    // energy low bytes first, then time
    assign blk_vec = {snap_t_r, snap_e_r};
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_blk_byte <= '0;
        end else if (16'(i_blk_idx) < BLK_BYTES) begin
            o_blk_byte <= blk_vec[8*i_blk_idx +: 8];
        end else begin
            o_blk_byte <= '0;
        end
    end

    // ********************
    // input supervision
    // ********************
    assign vin_mv = signed'({16'h0000, vin_r});

    // on above turn-on, off below turn-off
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conv_en <= 1'b0;
        end else if (vin_mv < l11_mv(lim_r[LIM_OFF])) begin
            o_conv_en <= 1'b0;
        end else if (vin_mv > l11_mv(lim_r[LIM_ON])) begin
            o_conv_en <= 1'b1;
        end
    end

    genvar g;
    for (g = 0; g < NUM_FLAG; g++) begin : g_lim
        always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_limit_flags[g] <= 1'b0;
            end else if (g < NUM_OV_FLAG) begin
                o_limit_flags[g] <= vin_mv > l11_mv(lim_r[LIM_FLAG0 + g]);
            end else begin
                o_limit_flags[g] <= vin_mv < l11_mv(lim_r[LIM_FLAG0 + g]);
            end
        end
    end

    // output pins off at once or after the turn-off delay
    for (g = 0; g < NUM_OUT; g++) begin : g_out
        logic [DW-1:0] dly_r;
        always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_out_en[g] <= 1'b0;
                dly_r       <= '0;
            end else if (o_conv_en) begin
                o_out_en[g] <= 1'b1;
                dly_r       <= '0;
            end else if (!i_off_sequenced || dly_r == TOFF_CNT) begin
                o_out_en[g] <= 1'b0;
            end else if (tick) begin
                dly_r <= dly_r + 1'b1;
            end
        end
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_clr_cmd;
        clr_req;
    endsequence
    sequence s_meter_zero;
        time_r == '0 && energy_r == '0;
    endsequence

    a_clear_meter: assert property (s_clr_cmd |-> ##[1:3] s_meter_zero)
        else $error("clear did not zero meter");
    a_clear_ack: assert property (clr_req |=> o_cmd_ack)
        else $error("clear not acknowledged");
    a_time_step: assert property (tick && !clr_apply |=> time_r == $past(time_r) + 1'b1)
        else $error("time did not advance on tick");
    a_snap_freeze: assert property (i_blk_active ##1 i_blk_active |-> $stable(snap_e_r)
                                    && $stable(snap_t_r))
        else $error("snapshot moved during block read");
    a_snap_pair: assert property (!i_blk_active |=> snap_e_r == $past(energy_r)
                                  && snap_t_r == $past(time_r))
        else $error("snapshot pair not coherent");
    a_cfg_reserved: assert property (cfg_r[7:3] == '0)
        else $error("reserved config bits set");
    a_hd_sched: assert property (i_adc_done && seq_r == SEQ_OTHER && cfg_r[CFG_HD_BIT]
                                 |=> seq_r == SEQ_VIN ##0 o_adc_sel == ADC_CH_VIN)
        else $error("hd mode skipped voltage slot");
    a_power_calc: assert property (i_adc_done && seq_r == SEQ_IIN
                                   |=> power_r == 32'($past(vin_r)) * 32'($past(i_adc_data)))
        else $error("power not product of pair");
    a_no_underflow: assert property (i_chan_off && energy_r == '0 |=> energy_r == '0)
        else $error("energy dropped below zero");
    a_blk_byte0: assert property (i_blk_idx == 4'h0 |=> o_blk_byte == $past(snap_e_r[7:0]))
        else $error("block byte 0 not energy low byte");
endmodule
`default_nettype wire

// >>> bench/iem_adc_model.sv
// converter partner model answering each channel selection
`timescale 1ns/100ps
`default_nettype none
module iem_adc_model
    import iem_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_sel,
    input  wire logic [15:0] i_vin_mv,
    input  wire logic [15:0] i_iin_ma,
    output logic             o_done,
    output logic [15:0]      o_data
);
    integer seed = 23365;
    int     gap;
    always @(negedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
            gap    <= 3;
            o_data <= 16'h0000;
        end else if (gap == 0) begin
            o_done <= 1'b1;
            o_data <= (i_sel == ADC_CH_VIN) ? i_vin_mv :
                      (i_sel == ADC_CH_IIN) ? i_iin_ma : 16'($random(seed));
            // gap of 2..5 keeps the next selection settled
            gap    <= 2 + ($random(seed) & 3);
        end else begin
            // data is not held outside a result
            o_done <= 1'b0;
            o_data <= ~o_data;
            gap    <= gap - 1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/iem_top_test.sv
// self-checking bench for the energy meter bank
`timescale 1ns/100ps
`default_nettype none
module iem_top_test;
    import iem_pkg::*;
    logic        clk = 1'b0;
    logic        rn = 1'b0;
    logic        v = 1'b0;
    logic        w = 1'b0;
    logic [7:0]  c = 8'h00;
    logic [15:0] d = 16'h0000;
    logic [1:0]  wp = 2'h0;
    logic        ba = 1'b0;
    logic [3:0]  bi = 4'h0;
    logic        off = 1'b0;
    logic        sq = 1'b0;
    logic [15:0] vin = 16'h0000;
    logic [15:0] iin = 16'h01F4;
    logic        done, ack, nack, hd, ce;
    logic [15:0] adat, rd, tc, gn, r;
    logic [7:0]  bb;
    logic [3:0]  sel, fl;
    logic [1:0]  rng, oe;
    logic [17:0] q[$];
    logic [17:0] e;
    logic [47:0] en, tm;
    int          fails = 0;
    int          compares = 0;
    int          dn, ve, i, k;
    integer      seed = 23365;
    logic [7:0]  cd[9] = '{CMD_VIN_ON, CMD_VIN_OFF, CMD_OV_FLT, CMD_OV_WRN, CMD_UV_WRN,
                           CMD_UV_FLT, CMD_EIN_CFG, CMD_GAIN_TC, CMD_GAIN};
    logic [15:0] dv[9] = '{RST_VIN_ON, RST_VIN_OFF, RST_OV_FLT, RST_OV_WRN, RST_UV_WRN,
                           RST_UV_FLT, {8'h00, RST_CFG}, RST_GAIN_TC, RST_GAIN};
    // hysteresis walk: on above 10 V, off below 9 V
    logic [15:0] lv[5] = '{16'd12000, 16'd14500, 16'd9500, 16'd8000, 16'd9500};
    logic [6:0]  lx[5] = '{7'h70, 7'h72, 7'h70, 7'h00, 7'h00};
    always #12.5 clk = ~clk;
    iem_top #(.P_CYC_PER_MS(8), .P_TOFF_MS(2)) iem_top_i (
        .i_ref_clk(clk), .i_rst_n(rn), .i_cmd_valid(v), .i_cmd_write(w), .i_cmd_code(c),
        .i_cmd_wdata(d), .i_wp_level(wp), .i_blk_active(ba), .i_blk_idx(bi),
        .i_adc_done(done), .i_adc_data(adat), .i_chan_off(off), .i_off_sequenced(sq),
        .o_cmd_ack(ack), .o_cmd_nack(nack), .o_rd_data(rd), .o_blk_byte(bb),
        .o_adc_sel(sel), .o_hd_select(hd), .o_iin_range(rng), .o_tempco(tc),
        .o_sense_gain(gn), .o_conv_en(ce), .o_out_en(oe), .o_limit_flags(fl));
    iem_adc_model iem_adc_model_i (.i_ref_clk(clk), .i_rst_n(rn), .i_sel(sel),
        .i_vin_mv(vin), .i_iin_ma(iin), .o_done(done), .o_data(adat));
    task stop_test;
        if (q.size() != 0) fails++;
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            $display("MISMATCH %0t %s", $time, m);
            fails++;
        end
    endtask
    task cmd(input logic wr, input logic [7:0] cc, input logic [15:0] wd,
             input logic nk, input logic [15:0] ed);
        @(negedge clk);
        v = 1'b1;
        w = wr;
        c = cc;
        d = wd;
        q.push_back({nk, !wr && !nk, ed});
        @(negedge clk);
        v = 1'b0;
    endtask
    task rst;
        rn = 1'b0;
        repeat (6) @(negedge clk);
        rn = 1'b1;
    endtask
    task defaults;
        for (int j = 0; j < 9; j++)
            cmd(1'b0, cd[j], 16'h0000, 1'b0, dv[j]);
    endtask
    task blk;
        @(negedge clk);
        ba = 1'b1;
        for (int j = 0; j < 12; j++) begin
            bi = 4'(j);
            @(negedge clk);
            if (j < 6) en[j*8 +: 8] = bb;
            else tm[(j-6)*8 +: 8] = bb;
        end
        repeat (40) @(negedge clk);
        bi = 4'h6;
        @(negedge clk);
        chk(bb === tm[7:0], "frozen copy moved");
        bi = 4'hC;
        @(negedge clk);
        chk(bb === 8'h00, "byte past block");
        ba = 1'b0;
    endtask
    task adc_count(input int lo, input int hi);
        @(negedge clk);
        dn = 0;
        ve = 0;
        for (k = 0; k < 3000 && dn < 36; k++) @(negedge clk);
        if (dn < 36) begin
            chk(1'b0, "converter stalled");
            stop_test();
        end
        chk(ve >= lo && ve <= hi, "voltage share");
    endtask
    always @(posedge clk) begin
        if (done === 1'b1) begin
            dn++;
            if (sel == ADC_CH_VIN) ve++;
        end
    end
    // answers are paired with the oldest note
    always @(negedge clk) begin
        if (ack === 1'b1 || nack === 1'b1) begin
            if (q.size() == 0) chk(1'b0, "unexpected answer");
            else begin
                e = q.pop_front();
                chk(nack === e[17] && ack === !e[17], "ack or nack");
                if (e[16]) chk(rd === e[15:0], "read data");
            end
        end
    end
    initial begin
        rst();
        defaults();
        sq = 1'b1;
        vin = 16'd12000;
        repeat (80) @(negedge clk);
        vin = 16'd8000;
        for (k = 0; k < 100 && ce === 1'b1; k++) @(negedge clk);
        chk(ce === 1'b0 && oe === 2'b11, "outputs dropped early");
        repeat (40) @(negedge clk);
        chk(oe === 2'b00, "outputs not dropped");
        sq = 1'b0;
        for (i = 0; i < 5; i++) begin
            vin = lv[i];
            repeat (80) @(negedge clk);
            chk({ce, oe, fl} === lx[i], "supervision");
        end
        vin = 16'd12000;
        repeat (80) @(negedge clk);
        cmd(1'b1, CMD_CLR, 16'h0000, 1'b0, 16'h0000);
        repeat (200) @(negedge clk);
        blk();
        chk(tm >= 23 && tm <= 27, "elapsed time");
        chk(en <= 6*tm && en + 12 >= 6*tm, "energy");
        off = 1'b1;
        repeat (2000) @(negedge clk);
        blk();
        chk(en === 48'h0 && tm > 70, "drain floor");
        off = 1'b0;
        cmd(1'b1, CMD_EIN_CFG, 16'h0006, 1'b0, 16'h0000);
        cmd(1'b0, CMD_EIN_CFG, 16'h0000, 1'b0, 16'h0006);
        chk(hd === 1'b1 && rng === 2'h2, "config outputs");
        blk();
        chk(tm <= 4, "config clear");
        adc_count(11, 14);
        cmd(1'b1, CMD_EIN_CFG, 16'h00F8, 1'b0, 16'h0000);
        cmd(1'b0, CMD_EIN_CFG, 16'h0000, 1'b0, 16'h0000);
        adc_count(4, 5);
        for (i = 1; i < 4; i++) begin
            wp = 2'(i);
            cmd(1'b1, CMD_VIN_ON, 16'h1234, 1'b1, 16'h0000);
            cmd(1'b1, CMD_CLR, 16'h0000, 1'b0, 16'h0000);
        end
        wp = 2'h0;
        cmd(1'b0, CMD_VIN_ON, 16'h0000, 1'b0, RST_VIN_ON);
        cmd(1'b0, CMD_EIN, 16'h0000, 1'b0, BLK_BYTES);
        cmd(1'b1, CMD_EIN, 16'h0001, 1'b1, 16'h0000);
        cmd(1'b0, CMD_CLR, 16'h0000, 1'b1, 16'h0000);
        cmd(1'b0, 8'h00, 16'h0000, 1'b1, 16'h0000);
        for (i = 0; i < 9; i++) begin
            r = 16'($random(seed));
            cmd(1'b1, cd[i], r, 1'b0, 16'h0000);
            cmd(1'b0, cd[i], 16'h0000, 1'b0, (cd[i] == CMD_EIN_CFG) ? (r & 16'h0007) : r);
            if (cd[i] == CMD_GAIN_TC) chk(tc === r, "tempco output");
        end
        chk(gn === r, "gain output");
        rst();
        defaults();
        repeat (4) @(negedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
